/* bench/bus_access_security_lock_tb.sv */
// Self-checking bench for the bus access security lock
`default_nettype none
module bus_access_security_lock_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import security_lock_pkg::*;
  localparam int LIMIT = 2;
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [1:0] wz = 2'h0, rz = 2'h0, meth = 2'h0, cls = 2'h0;
  logic [15:0] key = 16'h1234, att_d = 16'h0000;
  logic kst = 1'b0, en = 1'b0, att_w = 1'b0, wp_w = 1'b0, rv = 1'b0, rw = 1'b0, lvl = 1'b0;
  logic [3:0] code = 4'ha;
  logic [7:0] wp_d = 8'h00;
  logic pin, grant, locked, lockout, cap;
  logic [15:0] katt;
  logic [3:0] off;
  logic [7:0] wp;
  logic e_lk = 1'b1, e_lo = 1'b0, e_cap = 1'b0;
  logic [15:0] e_att = 16'h0000;
  logic [7:0] e_wp = 8'h00;
  logic [3:0] e_off = 4'h0;
  logic [31:0] exp_q[$];
  logic [31:0] rng = 32'h35551525;
  int num_errors = 0, num_checks = 0, wc = 0;

  always #2.5 sys_clk_in = ~sys_clk_in;

  bus_access_security_lock #(.WRONG_LIMIT(LIMIT), .ADDR_W(4)) u_dut (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .write_zone_in(wz), .read_zone_in(rz),
    .unlock_method_in(meth), .stored_unlock_key_in(key), .key_stored_in(kst),
    .device_enable_in(en), .address_lock_dual_pin_code_in(code),
    .address_lock_dual_pin_in(pin), .attempt_write_in(att_w), .attempt_data_in(att_d),
    .wp_write_in(wp_w), .wp_data_in(wp_d), .req_valid_in(rv), .req_write_in(rw),
    .req_class_in(cls), .req_grant_out(grant), .locked_out(locked), .lockout_out(lockout),
    .key_attempt_out(katt), .address_offset_out(off), .address_captured_out(cap),
    .write_protect_out(wp));

  lock_pin_driver u_pin (.clk_in(sys_clk_in), .captured_in(cap), .level_in(lvl), .pin_out(pin));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  // Expected grant from the zone tables; key class always reachable
  function automatic logic gate(input logic [1:0] r, w, c, input logic wr, lk);
    if (!lk || c == 2'h3) return 1'b1;
    if (wr) return (w == 2'h0) || (w == 2'h1 && c != 2'h0);
    return (r == 2'h0) || (r == 2'h1 && c != 2'h0) || (r == 2'h2 && c == 2'h2);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    num_checks++;
    if (seen !== expv) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic note(input logic g);
    exp_q.push_back({e_lo, e_lk, e_att, g, e_wp, e_cap, e_off});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask

  // Password-mode bookkeeping; other modes override the lock result
  task automatic attempt(input logic [15:0] d);
    tick(1);
    att_w <= 1'b1;
    att_d <= d;
    tick(1);
    att_w <= 1'b0;
    if (!e_lo) begin
      e_att = d;
      e_lk = !(d == key && key != 16'h0000);
      wc = e_lk ? wc + 1 : 0;
      e_lo = (wc == LIMIT);
    end
  endtask

  task automatic wp_write(input logic [7:0] v);
    tick(1);
    wp_w <= 1'b1;
    wp_d <= v;
    tick(1);
    wp_w <= 1'b0;
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0 && exp_q.size() == 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Result watcher: one note is consumed per settled cycle
  always @(negedge sys_clk_in) begin
    if (exp_q.size() > 0) begin
      check({lockout, locked, katt, grant, wp, cap, off}, exp_q.pop_front());
    end
  end

  // Hang guard
  initial begin
    tick(5000);
    num_errors++;
    wrap_up();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] r;
    tick(20);
    reset_in <= 1'b0;
    note(1'b0);
    tick(1);
    en <= 1'b1;
    tick(1);
    code <= 4'h5;
    e_cap = 1'b1;
    e_off = 4'ha;
    note(1'b0);
    tick(2);
    note(1'b0);
    // Locked access over every zone and direction, every class except security
    for (int z = 0; z < 32; z++) begin
      for (int c = 0; c < 3; c++) begin
        tick(1);
        rv <= 1'b1;
        rz <= z[1:0];
        wz <= z[3:2];
        rw <= z[4];
        cls <= c[1:0];
        note(gate(z[1:0], z[3:2], c[1:0], z[4], 1'b1));
      end
    end
    tick(1);
    rv <= 1'b0;
    wz <= 2'h2;
    wp_write(8'h5a);
    note(1'b0);
    wz <= 2'h0;
    wp_write(8'ha5);
    e_wp = 8'ha5;
    note(1'b0);
    attempt(key);
    note(1'b0);
    r = xs();
    tick(1);
    rv <= 1'b1;
    rz <= 2'h3;
    wz <= 2'h2;
    rw <= r[4];
    cls <= r[1:0];
    note(1'b1);
    attempt(xs() | 16'h8000);
    rv <= 1'b0;
    note(1'b0);
    attempt(key);
    note(1'b0);
    tick(1);
    kst <= 1'b1;
    key <= 16'h4321;
    tick(1);
    kst <= 1'b0;
    e_lk = 1'b1;
    note(1'b0);
    attempt(16'h4321);
    note(1'b0);
    tick(1);
    meth <= 2'h1;
    tick(2);
    e_lk = 1'b1;
    note(1'b0);
    lvl <= 1'b1;
    tick(2);
    e_lk = 1'b0;
    note(1'b0);
    lvl <= 1'b0;
    tick(2);
    e_lk = 1'b1;
    note(1'b0);
    meth <= 2'h2;
    lvl <= 1'b1;
    tick(2);
    e_lk = 1'b0;
    note(1'b0);
    lvl <= 1'b0;
    tick(2);
    e_lk = 1'b1;
    note(1'b0);
    lvl <= 1'b1;
    attempt(xs() | 16'h8000);
    note(1'b0);
    meth <= 2'h3;
    attempt(key);
    e_lk = 1'b1;
    tick(1);
    note(1'b0);
    meth <= 2'h0;
    attempt(key);
    tick(1);
    note(1'b0);
    for (int i = 0; i < LIMIT; i++) begin
      attempt(xs() | 16'h8000);
      note(1'b0);
    end
    attempt(key);
    note(1'b0);
    tick(1);
    reset_in <= 1'b1;
    tick(1);
    reset_in <= 1'b0;
    e_lk = 1'b1;
    e_lo = 1'b0;
    e_att = 16'h0000;
    e_wp = 8'h00;
    e_cap = 1'b0;
    e_off = 4'h0;
    wc = 0;
    note(1'b0);
    tick(1);
    key <= 16'h0000;
    e_cap = 1'b1;
    e_off = 4'h5;
    note(1'b0);
    attempt(16'h0000);
    note(1'b0);
    @(negedge sys_clk_in);
    @(negedge sys_clk_in);
    wrap_up();
  end
endmodule
`default_nettype wire

/* bench/lock_pin_driver.sv */
// Board-side driver model for the dual address/lock pin
`default_nettype none
module lock_pin_driver (
  input wire logic clk_in,
  input wire logic captured_in,
  input wire logic level_in,
  output logic pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wiggle = 1'b0;
  // Floating pin: a changing pattern, so a stale level cannot pass for a real one
  always @(posedge clk_in) begin
    wiggle <= ~wiggle;
  end
  // Lock level driven only after the offset is latched; the lock ignores the pin until then
  assign pin_out = captured_in ? level_in : wiggle;
endmodule
`default_nettype wire

/* core/bus_access_security_lock.sv */
// Lock state, key attempts, lock pin and zone gating for the management port registers
// Functional notes
// R1 - Write zone selection: open, no-configuration, secure; default open.
// R2 - Read zone selection: open, no-configuration, telemetry, secure; default open.
// R3 - Locked reads: all, debug+telemetry, telemetry, none; unlocked reads all.
// R4 - Locked writes: all, debug+telemetry, none; unlocked writes all.
// R5 - Unlock methods: password, pin, pin plus password, permanent lock.
// R6 - Sixteen-bit stored key; zero is never a valid key.
// R7 - Writing the stored key into the attempt register unlocks.
// R8 - Writing any other value into the attempt register locks.
// R9 - Wrong attempts counted; at the limit further attempts are refused.
// R10 - Host changes key: unlock, store new key, then retry with it.
// R11 - Storing a new key leaves the device locked.
// R12 - Address offset sampled once from the dual pin at enable.
// R13 - After capture the dual pin serves only as lock input.
// R14 - In pin modes, pin high unlocks and pin low locks.
// R15 - Board keeps the pin undriven until the offset is sampled.
// R16 - Byte-wide write-protect command register, zero after reset.
// R17 - Pin plus password needs both; permanent lock never unlocks.
// R18 - Wrong-attempt limit is a parameter; counter clears on reset or unlock (here on reset or a correct key; a pin-mode unlock leaves it).
`default_nettype none
module bus_access_security_lock #(
  parameter int WRONG_LIMIT = security_lock_pkg::WRONG_LIMIT_DEFAULT,
  parameter int ADDR_W = 4
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [1:0] write_zone_in,
  input wire logic [1:0] read_zone_in,
  input wire logic [1:0] unlock_method_in,
  input wire logic [security_lock_pkg::KEY_W-1:0] stored_unlock_key_in,
  input wire logic key_stored_in,
  input wire logic device_enable_in,
  input wire logic [ADDR_W-1:0] address_lock_dual_pin_code_in,
  input wire logic address_lock_dual_pin_in,
  input wire logic attempt_write_in,
  input wire logic [security_lock_pkg::KEY_W-1:0] attempt_data_in,
  input wire logic wp_write_in,
  input wire logic [security_lock_pkg::WP_W-1:0] wp_data_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [1:0] req_class_in,
  output logic req_grant_out,
  output logic locked_out,
  output logic lockout_out,
  output logic [security_lock_pkg::KEY_W-1:0] key_attempt_out,
  output logic [ADDR_W-1:0] address_offset_out,
  output logic address_captured_out,
  output logic [security_lock_pkg::WP_W-1:0] write_protect_out
);
  import security_lock_pkg::*;

  localparam int CNT_W = $clog2(WRONG_LIMIT + 1);
  localparam logic [CNT_W-1:0] LIMIT_CNT = CNT_W'(WRONG_LIMIT);

  // ****************************************
  // Elaboration checks
  // ****************************************
  // A limit of zero would lock out before the first try
  if (WRONG_LIMIT < 1 || WRONG_LIMIT > 255) begin : g_bad_limit
    $error("WRONG_LIMIT must be 1 to 255");
  end
  if (ADDR_W < 1) begin : g_bad_addr
    $error("ADDR_W must be at least 1");
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    lock_state_e lock_state;
    logic key_match;
    logic [CNT_W-1:0] wrong_count;
    logic [KEY_W-1:0] attempt;
    logic addr_captured;
    logic [ADDR_W-1:0] addr_offset;
    logic [WP_W-1:0] write_protect;
  } state_s;

  state_s state;
  state_s next_state;
  logic key_valid;
  logic attempt_ok;
  logic pin_unlock;
  logic unlock_cond;
  logic locked_now;
  logic wp_allowed;

  assign locked_now = (state.lock_state != ST_UNLOCKED);
  assign key_valid = (stored_unlock_key_in != KEY_INVALID); // R6
  assign attempt_ok = key_valid && (attempt_data_in == stored_unlock_key_in);
  // Pin level only counts once the address offset is latched
  assign pin_unlock = state.addr_captured && address_lock_dual_pin_in; // R13 R14
  // Write-protect byte is a configuration register itself
  assign wp_allowed = write_allowed(write_zone_in, locked_now, CLASS_CONFIG);

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    next_state = state;
    unlock_cond = 1'b0;
    // Dual pin sampled once at enable, never again
    if (device_enable_in && !state.addr_captured) begin
      next_state.addr_captured = 1'b1; // R12
      next_state.addr_offset = address_lock_dual_pin_code_in; // R12
    end
    // Attempts are refused once locked out; register holds its value
    if (attempt_write_in && state.lock_state != ST_LOCKED_OUT) begin
      next_state.attempt = attempt_data_in; // R7
      if (attempt_ok) begin
        next_state.key_match = 1'b1; // R7
        next_state.wrong_count = '0; // R18
      end else begin
        next_state.key_match = 1'b0; // R8
        if (state.wrong_count < LIMIT_CNT) begin
          next_state.wrong_count = state.wrong_count + CNT_W'(1); // R9
        end
      end
    end
    // Storing a key wins over a same-cycle attempt
    if (key_stored_in) begin
      next_state.key_match = 1'b0; // R11
    end
    if (wp_write_in && wp_allowed) begin
      next_state.write_protect = wp_data_in; // R16
    end
    case (unlock_method_in)
      METHOD_PASSWORD: unlock_cond = next_state.key_match; // R5
      METHOD_PIN: unlock_cond = pin_unlock; // R14
      METHOD_PIN_PASSWORD: unlock_cond = pin_unlock && next_state.key_match; // R17
      METHOD_FOREVER: unlock_cond = 1'b0; // R17
      default: unlock_cond = 1'b0;
    endcase
    // Lockout is sticky until power-on reset, whatever the method
    case (state.lock_state)
      ST_LOCKED_OUT: next_state.lock_state = ST_LOCKED_OUT; // R9
      ST_LOCKED, ST_UNLOCKED: begin
        if (next_state.wrong_count >= LIMIT_CNT) begin
          next_state.lock_state = ST_LOCKED_OUT; // R9
        end else if (unlock_cond) begin
          next_state.lock_state = ST_UNLOCKED;
        end else begin
          next_state.lock_state = ST_LOCKED;
        end
      end
      default: next_state.lock_state = ST_LOCKED_OUT;
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  // Power-on reset: locked, open zones come from the store, counters clear
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state.lock_state <= ST_LOCKED;
      state.key_match <= 1'b0;
      state.wrong_count <= '0; // R18
      state.attempt <= ATTEMPT_RESET;
      state.addr_captured <= 1'b0;
      state.addr_offset <= '0;
      state.write_protect <= WRITE_PROTECT_RESET; // R16
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // Access gate and outputs
  // ****************************************
  // Zone selections default to open in the store, so all passes after erase
  zone_access_check u_zone_check (
    .read_zone_in(read_zone_in), // R2
    .write_zone_in(write_zone_in), // R1
    .locked_in(locked_now),
    .valid_in(req_valid_in),
    .is_write_in(req_write_in),
    .class_in(req_class_in),
    .grant_out(req_grant_out)
  );

  assign locked_out = locked_now;
  assign lockout_out = (state.lock_state == ST_LOCKED_OUT);
  assign key_attempt_out = state.attempt;
  assign address_offset_out = state.addr_offset;
  assign address_captured_out = state.addr_captured;
  assign write_protect_out = state.write_protect;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);

  property p_forever_locked;
    (unlock_method_in == METHOD_FOREVER) && $past(unlock_method_in == METHOD_FOREVER)
      |-> locked_out;
  endproperty
  a_forever_locked: assert property (p_forever_locked) // R17
    else $error("unlocked in permanent lock mode");

  property p_good_key_unlocks;
    attempt_write_in && attempt_ok && !lockout_out && !key_stored_in
      && unlock_method_in == METHOD_PASSWORD ##1 unlock_method_in == METHOD_PASSWORD
      |-> !locked_out;
  endproperty
  a_good_key_unlocks: assert property (p_good_key_unlocks) // R7
    else $error("correct key did not unlock");

  property p_bad_key_locks;
    attempt_write_in && !attempt_ok && !lockout_out
      && unlock_method_in != METHOD_PIN |=> locked_out;
  endproperty
  a_bad_key_locks: assert property (p_bad_key_locks) // R8
    else $error("wrong key left device unlocked");

  property p_store_locks;
    key_stored_in && unlock_method_in != METHOD_PIN
      ##1 unlock_method_in != METHOD_PIN |-> locked_out;
  endproperty
  a_store_locks: assert property (p_store_locks) // R11
    else $error("device unlocked after key store");

  property p_lockout_sticky;
    lockout_out |=> lockout_out && locked_out;
  endproperty
  a_lockout_sticky: assert property (p_lockout_sticky) // R9
    else $error("lockout released without reset");

  property p_lockout_refuses;
    lockout_out && attempt_write_in |=> $stable(key_attempt_out);
  endproperty
  a_lockout_refuses: assert property (p_lockout_refuses) // R9
    else $error("attempt taken while locked out");

  property p_limit_reached;
    attempt_write_in && !attempt_ok && !lockout_out
      && state.wrong_count == LIMIT_CNT - CNT_W'(1) |=> lockout_out;
  endproperty
  a_limit_reached: assert property (p_limit_reached) // R18
    else $error("limit reached without lockout");

  property p_addr_once;
    address_captured_out |=> address_captured_out && $stable(address_offset_out);
  endproperty
  a_addr_once: assert property (p_addr_once) // R12
    else $error("address offset changed after capture");

  property p_pin_mode;
    unlock_method_in == METHOD_PIN && address_captured_out && !lockout_out
      && !attempt_write_in ##1 unlock_method_in == METHOD_PIN
      |-> locked_out == !$past(address_lock_dual_pin_in);
  endproperty
  a_pin_mode: assert property (p_pin_mode) // R14
    else $error("lock state does not follow pin");

  property p_secure_read;
    req_valid_in && !req_write_in && locked_out && read_zone_in == RZONE_SECURE
      && req_class_in != CLASS_SECURITY |-> !req_grant_out;
  endproperty
  a_secure_read: assert property (p_secure_read) // R3
    else $error("read granted in secure zone while locked");

  property p_nocfg_write;
    req_valid_in && req_write_in && locked_out && write_zone_in == WZONE_NO_CONFIG
      |-> req_grant_out == (req_class_in != CLASS_CONFIG);
  endproperty
  a_nocfg_write: assert property (p_nocfg_write) // R4
    else $error("no-configuration write gating wrong");

  property p_wp_reset;
    $fell(reset_in) |-> write_protect_out == WRITE_PROTECT_RESET;
  endproperty
  a_wp_reset: assert property (p_wp_reset) // R16
    else $error("write-protect byte not zero after reset");

  property p_zero_key;
    attempt_write_in && stored_unlock_key_in == KEY_INVALID && !lockout_out
      && unlock_method_in == METHOD_PASSWORD |=> locked_out;
  endproperty
  a_zero_key: assert property (p_zero_key) // R6
    else $error("zero key unlocked the device");

  property p_wp_refused;
    wp_write_in && locked_out && write_zone_in == WZONE_SECURE
      |=> $stable(write_protect_out);
  endproperty
  a_wp_refused: assert property (p_wp_refused) // R16
    else $error("write-protect byte changed in secure zone");

  property p_wp_taken;
    wp_write_in && write_zone_in == WZONE_OPEN
      |=> write_protect_out == $past(wp_data_in);
  endproperty
  a_wp_taken: assert property (p_wp_taken) // R16
    else $error("write-protect byte not taken in open zone");

  property p_unlocked_all;
    req_valid_in && !locked_out
      |-> req_grant_out;
  endproperty
  a_unlocked_all: assert property (p_unlocked_all) // R3 R4
    else $error("access refused while unlocked");

  c_password_unlock: cover property ($fell(locked_out) && unlock_method_in == METHOD_PASSWORD);
  c_lockout: cover property ($rose(lockout_out));
  c_pin_unlock: cover property ($fell(locked_out) && unlock_method_in == METHOD_PIN);
  c_denied: cover property (req_valid_in && !req_grant_out);
  c_wp_refused: cover property (wp_write_in && locked_out && write_zone_in == WZONE_SECURE);
endmodule
`default_nettype wire

/* core/security_lock_pkg.sv */
// Shared constants, encodings and access decisions for the bus access security lock
`default_nettype none
package security_lock_pkg;

  // ****************************************
  // Widths and values after reset
  // ****************************************
  localparam int KEY_W = 16;
  localparam int WP_W = 8;
  localparam logic [KEY_W-1:0] KEY_INVALID = 16'h0000;
  localparam logic [KEY_W-1:0] ATTEMPT_RESET = 16'h0000;
  localparam logic [WP_W-1:0] WRITE_PROTECT_RESET = 8'h00;
  localparam logic [7:0] WRITE_PROTECT_CMD = 8'h10;
  localparam int WRONG_LIMIT_DEFAULT = 3;

  // ****************************************
  // Zone, method and register class codes
  // ****************************************
  localparam logic [1:0] WZONE_OPEN = 2'h0;
  localparam logic [1:0] WZONE_NO_CONFIG = 2'h1;
  localparam logic [1:0] WZONE_SECURE = 2'h2;
  localparam logic [1:0] RZONE_OPEN = 2'h0;
  localparam logic [1:0] RZONE_NO_CONFIG = 2'h1;
  localparam logic [1:0] RZONE_TELEMETRY = 2'h2;
  localparam logic [1:0] RZONE_SECURE = 2'h3;

  localparam logic [1:0] METHOD_PASSWORD = 2'h0;
  localparam logic [1:0] METHOD_PIN = 2'h1;
  localparam logic [1:0] METHOD_PIN_PASSWORD = 2'h2;
  localparam logic [1:0] METHOD_FOREVER = 2'h3;

  localparam logic [1:0] CLASS_CONFIG = 2'h0;
  localparam logic [1:0] CLASS_DEBUG = 2'h1;
  localparam logic [1:0] CLASS_TELEMETRY = 2'h2;
  localparam logic [1:0] CLASS_SECURITY = 2'h3;

  typedef enum logic [2:0] {
    ST_LOCKED = 3'b001,
    ST_UNLOCKED = 3'b010,
    ST_LOCKED_OUT = 3'b100
  } lock_state_e;

  // ****************************************
  // Access decisions
  // ****************************************
  // Security class stays reachable so a locked part can still be unlocked
  function automatic logic read_allowed(input logic [1:0] zone, input logic locked,
                                        input logic [1:0] cls);
    logic ok;
    ok = 1'b0;
    if (!locked || cls == CLASS_SECURITY) begin
      ok = 1'b1;
    end else begin
      case (zone)
        RZONE_OPEN: ok = 1'b1;
        RZONE_NO_CONFIG: ok = (cls == CLASS_DEBUG) || (cls == CLASS_TELEMETRY);
        RZONE_TELEMETRY: ok = (cls == CLASS_TELEMETRY);
        default: ok = 1'b0;
      endcase
    end
    return ok;
  endfunction

  // Unused write code 3 is treated as secure, the safe side
  function automatic logic write_allowed(input logic [1:0] zone, input logic locked,
                                         input logic [1:0] cls);
    logic ok;
    ok = 1'b0;
    if (!locked || cls == CLASS_SECURITY) begin
      ok = 1'b1;
    end else begin
      case (zone)
        WZONE_OPEN: ok = 1'b1;
        WZONE_NO_CONFIG: ok = (cls == CLASS_DEBUG) || (cls == CLASS_TELEMETRY);
        default: ok = 1'b0;
      endcase
    end
    return ok;
  endfunction

endpackage
`default_nettype wire

/* core/zone_access_check.sv */
// Combinational read/write permission check for one register access request
`default_nettype none
module zone_access_check (
  input wire logic [1:0] read_zone_in,
  input wire logic [1:0] write_zone_in,
  input wire logic locked_in,
  input wire logic valid_in,
  input wire logic is_write_in,
  input wire logic [1:0] class_in,
  output logic grant_out
);
  import security_lock_pkg::*;

  // ****************************************
  // Zone lookup
  // ****************************************
  // Reads and writes use separate zone selections
  always_comb begin
    if (!valid_in) begin
      grant_out = 1'b0;
    end else if (is_write_in) begin
      grant_out = write_allowed(write_zone_in, locked_in, class_in); // R4
    end else begin
      grant_out = read_allowed(read_zone_in, locked_in, class_in); // R3
    end
  end
endmodule
`default_nettype wire
